//--- core/adc_frame_device.sv
// Purpose: converter end of the serial frame
// Assumes: serial_clock and chip_select_n come from the host;
//          sample_in is the held analog value, stable at select fall
// Notes:   link logic runs on serial_clock and the select fall, user pulses on core_clk
`timescale 1ns/1ps
`default_nettype none
module adc_frame_device #(
   parameter int RESULT_W = adc_frame_pkg::RESULT_W
) (
   adc_link_if.device          link,
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic [RESULT_W-1:0] sample_in,
   output logic                     frame_start,
   output logic                     track_back
);

   // sample held from the select edge
   typedef struct packed {
      logic [RESULT_W-1:0] held;
      logic                frame_tgl;
   } smp_t;

   // rising-edge side of the frame
   typedef struct packed {
      logic [adc_frame_pkg::CNT_W-1:0] rise_cnt;
      logic                            track;
   } rise_t;

   // falling-edge side of the frame
   typedef struct packed {
      logic [adc_frame_pkg::CNT_W-1:0] fall_cnt;
      logic                            sdo;
      logic                            done;
   } fall_t;

   smp_t  smp_r;
   smp_t  smp_nxt;
   rise_t rise_r;
   rise_t rise_nxt;
   fall_t fall_r;
   fall_t fall_nxt;

   logic                            frame_rst;
   logic [adc_frame_pkg::CNT_W-1:0] fall_next;
   logic [adc_frame_pkg::CNT_W-1:0] bit_idx;

   // a raised select clears both edge sides, not the held sample; the clock may stop
   // outside frames, so nothing waits for an edge to end one
   assign frame_rst = rst | link.chip_select_n;

   // sample domain: clocked by the select falling edge itself
   always_comb
   begin
      smp_nxt           = smp_r;
      smp_nxt.held      = sample_in;
      smp_nxt.frame_tgl = ~smp_r.frame_tgl;
   end

   always_ff @(negedge link.chip_select_n or posedge rst)
   begin
      if (rst)
         smp_r <= '0;
      else
         smp_r <= smp_nxt;
   end

   // rising edges: count to the return to track
   always_comb
   begin
      rise_nxt = rise_r;
      if (rise_r.rise_cnt != adc_frame_pkg::RISE_TRACK)
      begin
         rise_nxt.rise_cnt = rise_r.rise_cnt + 5'h01;
      end
      if (rise_r.rise_cnt == adc_frame_pkg::RISE_TRACK - 5'h01)
      begin
         rise_nxt.track = 1'b1;
      end
   end

   always_ff @(posedge link.serial_clock or posedge frame_rst)
   begin
      if (frame_rst)
         rise_r <= '0;
      else
         rise_r <= rise_nxt;
   end

   // falling edges: count, launch bits, release after the last
   assign fall_next = fall_r.fall_cnt + 5'h01;
   assign bit_idx   = adc_frame_pkg::FALL_LAST_DATA - fall_next;

   always_comb
   begin
      fall_nxt = fall_r;
      if (!fall_r.done)
      begin
         fall_nxt.fall_cnt = fall_next;
         // zeros lead, data msb first; held word is stable since
         // it was written before the first clock edge of the frame
         if (fall_next >= adc_frame_pkg::FALL_FIRST_DATA &&
             fall_next <= adc_frame_pkg::FALL_LAST_DATA)
         begin
            fall_nxt.sdo = smp_r.held[bit_idx[3:0]];
         end
         else
         begin
            fall_nxt.sdo = 1'b0;
         end
         if (fall_next == adc_frame_pkg::FRAME_FALLS)
         begin
            fall_nxt.done = 1'b1;
         end
      end
   end

   always_ff @(negedge link.serial_clock or posedge frame_rst)
   begin
      if (frame_rst)
         fall_r <= '0;
      else
         fall_r <= fall_nxt;
   end

   // first zero is on the line as soon as select falls
   assign link.sdo_o    = fall_r.sdo;
   assign link.sdo_oe_n = frame_rst | fall_r.done;

   // core side: toggle for the start event, level for track;
   // track stays up until select rises, long enough to be seen
   pulse_sync #(
      .RISE_ONLY (1'b0)
   ) start_sync_i (
      .clk   (core_clk),
      .rst   (rst),
      .din   (smp_r.frame_tgl),
      .pulse (frame_start)
   );

   pulse_sync #(
      .RISE_ONLY (1'b1)
   ) track_sync_i (
      .clk   (core_clk),
      .rst   (rst),
      .din   (rise_r.track),
      .pulse (track_back)
   );

endmodule : adc_frame_device

// two flops, then a one-cycle pulse on a change of the level, or on a rise of it only when RISE_ONLY is set
module pulse_sync #(
   parameter bit RISE_ONLY = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      pulse
);

   // s3 only remembers s2 for the edge test
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic p;
   } sync_t;

   sync_t sync_r;
   sync_t sync_nxt;

   // only s2 and s3 feed logic: s1 may still be settling
   always_comb
   begin
      sync_nxt    = sync_r;
      sync_nxt.s1 = din;
      sync_nxt.s2 = sync_r.s1;
      sync_nxt.s3 = sync_r.s2;
      if (RISE_ONLY)
      begin
         sync_nxt.p = sync_r.s2 & ~sync_r.s3;
      end
      else
      begin
         sync_nxt.p = sync_r.s2 ^ sync_r.s3;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sync_r <= '0;
      else
         sync_r <= sync_nxt;
   end

   assign pulse = sync_r.p;

endmodule : pulse_sync
`default_nettype wire

//--- core/adc_frame_host.sv
// Purpose: serial host that runs one conversion frame per start
// Assumes: core_clk at 40 MHz; serial_clock made by a divider
// Notes:   serial_out_line synchronised before use
`timescale 1ns/1ps
`default_nettype none
module adc_frame_host #(
   parameter int SCLK_HALF_CYC = adc_frame_pkg::SCLK_HALF_CYC,
   parameter int GAP_CYC       = adc_frame_pkg::GAP_CYC,
   parameter int RESULT_W      = adc_frame_pkg::RESULT_W
) (
   adc_link_if.host             link,
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                start,
   output logic                     ready,
   output logic [RESULT_W-1:0]      result,
   output logic                     result_valid
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN  = 2'h1,
      ST_STOP = 2'h3,
      ST_GAP  = 2'h2
   } host_st_t;

   typedef struct packed {
      host_st_t                          st;
      logic                              cs_n;
      logic                              sclk;
      logic [7:0]                        div;
      logic [adc_frame_pkg::CNT_W-1:0]   falls;
      logic [7:0]                        gap;
      logic [adc_frame_pkg::FRAME_W-1:0] sreg;
      logic [RESULT_W-1:0]               res;
      logic                              valid;
      logic                              s1;
      logic                              s2;
   } host_t;

   localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
   localparam logic [7:0] GAP_LAST  = 8'(GAP_CYC - 1);
   localparam host_t HOST_RST = '{st: ST_IDLE, cs_n: 1'b1, sclk: 1'b1,
                                  default: '0};

   host_t r;
   host_t n;

   always_comb
   begin
      n       = r;
      n.valid = 1'b0;
      n.s1    = link.serial_out_line;
      n.s2    = r.s1;
      case (r.st)
         ST_IDLE:
         begin
            if (start)
            begin
               n.cs_n  = 1'b0;
               n.div   = '0;
               n.falls = '0;
               n.st    = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (r.div == HALF_LAST)
            begin
               n.div  = '0;
               n.sclk = ~r.sclk;
               if (r.sclk)
               begin
                  // capture the bit launched one fall earlier
                  n.falls = r.falls + 5'h01;
                  n.sreg  = {r.sreg[adc_frame_pkg::FRAME_W-2:0],
                             r.s2};
                  if (r.falls == adc_frame_pkg::FRAME_FALLS - 5'h01)
                  begin
                     n.st = ST_STOP;
                  end
               end
            end
            else
            begin
               n.div = r.div + 8'h01;
            end
         end
         ST_STOP:
         begin
            if (r.div == HALF_LAST)
            begin
               n.sclk  = 1'b1;
               n.cs_n  = 1'b1;
               // fixed slots: a fourth leading zero never reaches them
               n.res   = r.sreg[adc_frame_pkg::RES_LSB_POS +: RESULT_W];
               n.valid = 1'b1;
               n.gap   = '0;
               n.st    = ST_GAP;
            end
            else
            begin
               n.div = r.div + 8'h01;
            end
         end
         ST_GAP:
         begin
            // covers acquisition after track and the quiet gap
            if (r.gap == GAP_LAST)
            begin
               n.st = ST_IDLE;
            end
            else
            begin
               n.gap = r.gap + 8'h01;
            end
         end
         default:
         begin
            n = HOST_RST;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         r <= HOST_RST;
      else
         r <= n;
   end

   assign link.chip_select_n = r.cs_n;
   assign link.serial_clock  = r.sclk;
   assign ready              = (r.st == ST_IDLE);
   assign result             = r.res;
   assign result_valid       = r.valid;

endmodule : adc_frame_host
`default_nettype wire

//--- core/adc_frame_pkg.sv
// Purpose: shared constants of the serial converter frame
// Assumes: core_clk at 40 MHz
// Notes:   edge numbers count from the select falling edge
package adc_frame_pkg;
   localparam int RESULT_W    = 12;
   localparam int CNT_W       = 5;
   // falling-edge numbers within a frame
   localparam logic [4:0] FALL_FIRST_DATA = 5'h03;
   localparam logic [4:0] FALL_LAST_DATA  = 5'h0e;
   localparam logic [4:0] FRAME_FALLS     = 5'h10;
   // rising edge on which the converter returns to track
   localparam logic [4:0] RISE_TRACK      = 5'h0d;
   // host capture: result sits above the trailing bit
   localparam int RES_LSB_POS = 1;
   localparam int FRAME_W     = 16;
   // timing
   localparam int CORE_CLK_NS = 25;
   localparam int ACQ_NS      = 350;
   localparam int QUIET_NS    = 50;
   localparam int ACQ_CYC     = (ACQ_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int QUIET_CYC   = (QUIET_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int GAP_CYC     = (ACQ_CYC > QUIET_CYC) ? ACQ_CYC : QUIET_CYC;
   localparam int SCLK_HALF_CYC = 4;
endpackage : adc_frame_pkg

//--- core/adc_link_if.sv
// Purpose: three-wire link between converter and serial host
// Assumes: serial_out_line pulled high when nobody drives it
// Notes:   enable active low, resolved here
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
   logic chip_select_n;
   logic serial_clock;
   logic sdo_o;
   logic sdo_oe_n;
   logic serial_out_line;

   // released line reads as the pull-up level
   assign serial_out_line = sdo_oe_n ? 1'b1 : sdo_o;

   modport device (
      input  chip_select_n,
      input  serial_clock,
      output sdo_o,
      output sdo_oe_n
   );
   modport host (
      output chip_select_n,
      output serial_clock,
      input  serial_out_line
   );
endinterface : adc_link_if
`default_nettype wire

//--- verif/adc_frame_properties.sv
// Purpose: link checks beside the joined converter ends
// Assumes: serial_clock is made from core_clk by the host
// Notes:   falls counted in core_clk domain
`timescale 1ns/1ps
`default_nettype none
module adc_frame_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic sdo_o,
   input wire logic sdo_oe_n,
   input wire logic serial_out_line
);
   typedef struct packed {
      logic       sclk;
      logic [4:0] falls;
      logic [4:0] hi;
   } mon_t;
   mon_t       mon_r;
   mon_t       mon_nxt;
   logic       fall_now;
   logic [4:0] n_fall;
   assign fall_now = mon_r.sclk & ~serial_clock;
   // fall seen one edge late, so add it in
   assign n_fall = mon_r.falls + {4'h0, fall_now};
   always_comb
   begin
      mon_nxt = mon_r;
      mon_nxt.sclk = serial_clock;
      mon_nxt.falls = chip_select_n ? 5'h00 : n_fall;
      mon_nxt.hi = !chip_select_n ? 5'h00 :
                   (mon_r.hi == 5'h1f) ? mon_r.hi : mon_r.hi + 5'h01;
   end
   // idle gap starts saturated: a start may follow reset at once
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         mon_r <= '{sclk: 1'b1, falls: 5'h00, hi: 5'h1f};
      else
         mon_r <= mon_nxt;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_idle_released;
      chip_select_n |-> sdo_oe_n;
   endproperty
   property p_enable_at_select;
      $fell(chip_select_n) |-> !sdo_oe_n && !sdo_o && !serial_out_line;
   endproperty
   property p_leading_zeros;
      !chip_select_n && n_fall < 5'h03 |-> !serial_out_line;
   endproperty
   property p_trailing_zero;
      !chip_select_n && n_fall == 5'h0f |-> !serial_out_line;
   endproperty
   property p_held_to_16;
      !chip_select_n && n_fall < 5'h10 |-> !sdo_oe_n;
   endproperty
   property p_release_16;
      !chip_select_n && n_fall == 5'h10 |-> sdo_oe_n;
   endproperty
   property p_launch_on_fall;
      !chip_select_n && !$past(chip_select_n) && !fall_now
         |-> $stable(serial_out_line);
   endproperty
   property p_sixteen_clocks;
      $rose(chip_select_n) |-> mon_r.falls == 5'h10;
   endproperty
   property p_quiet_gap;
      $fell(chip_select_n) |-> mon_r.hi >= 5'h0e;
   endproperty
   a_idle_released: assert property (p_idle_released)
      else $error("line driven while deselected");
   a_enable_at_select: assert property (p_enable_at_select)
      else $error("line not driven low at select");
   a_leading_zeros: assert property (p_leading_zeros)
      else $error("leading bit not zero");
   a_trailing_zero: assert property (p_trailing_zero)
      else $error("trailing bit not zero");
   a_held_to_16: assert property (p_held_to_16)
      else $error("line released early");
   a_release_16: assert property (p_release_16)
      else $error("line not released after last fall");
   a_launch_on_fall: assert property (p_launch_on_fall)
      else $error("line changed off a falling edge");
   a_sixteen_clocks: assert property (p_sixteen_clocks)
      else $error("frame without sixteen clocks");
   a_quiet_gap: assert property (p_quiet_gap)
      else $error("select fell too soon");
   c_frame: cover property ($rose(chip_select_n) && mon_r.falls == 5'h10);
   c_data_one: cover property (n_fall == 5'h03 && serial_out_line);
   c_tight_gap: cover property ($fell(chip_select_n) && mon_r.hi < 5'h1f);
endmodule : adc_frame_properties
`default_nettype wire

//--- verif/serial_adc_conversion_frame_test.sv
// Purpose: both converter ends joined, plus a bench-driven device
// Assumes: host timing as handed over, H of four
// Notes:   second link clocked by the bench at 80 ns
`timescale 1ns/1ps
`default_nettype none
module serial_adc_conversion_frame_test;
   logic        core_clk;
   logic        rst;
   logic        start;
   logic        ready;
   logic        result_valid;
   logic        frame_start;
   logic        track_back;
   logic        frame_start2;
   logic [11:0] sample_in;
   logic [11:0] result;
   logic [11:0] sample2 = 12'hb4d;
   logic [11:0] codes[5] = '{12'h000, 12'hfff, 12'ha5a, 12'h001, 12'h800};
   int          n_errors = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          fs_cyc = 0;
   int          tr_cyc = 0;
   int          n_starts = 0;
   int          n_starts2 = 0;
   adc_link_if link();
   adc_link_if link2();
   adc_frame_device adc_frame_device_i (.link(link), .core_clk(core_clk),
      .rst(rst), .sample_in(sample_in), .frame_start(frame_start),
      .track_back(track_back));
   adc_frame_host adc_frame_host_i (.link(link), .core_clk(core_clk),
      .rst(rst), .start(start), .ready(ready), .result(result),
      .result_valid(result_valid));
   adc_frame_device adc_frame_device_i2 (.link(link2), .core_clk(core_clk),
      .rst(rst), .sample_in(sample2), .frame_start(frame_start2),
      .track_back());
   adc_frame_properties adc_frame_properties_i (.core_clk(core_clk),
      .rst(rst), .chip_select_n(link.chip_select_n),
      .serial_clock(link.serial_clock), .sdo_o(link.sdo_o),
      .sdo_oe_n(link.sdo_oe_n), .serial_out_line(link.serial_out_line));
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(negedge core_clk)
   begin
      cyc <= cyc + 1;
      if (frame_start) fs_cyc <= cyc;
      if (frame_start) n_starts <= n_starts + 1;
      if (track_back) tr_cyc <= cyc;
      if (frame_start2) n_starts2 <= n_starts2 + 1;
   end
   task check(input string what, input logic [31:0] exp,
              input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   task complete_run;
      $display("errors %0d, comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   // waits for ready, so successive calls run back to back
   task t_conv(input logic [11:0] v);
      int i;
      int n0;
      int gap;
      int gap_exp;
      i = 0;
      n0 = n_starts;
      // 13th rise lies 26 half periods after select fall
      gap_exp = 2 * int'(adc_frame_pkg::RISE_TRACK) *
                adc_frame_pkg::SCLK_HALF_CYC;
      @(negedge core_clk);
      while (!ready && i < 40)
      begin
         @(negedge core_clk);
         i++;
      end
      check("ready", 1, ready);
      sample_in = v;
      start = 1'b1;
      @(negedge core_clk);
      start = 1'b0;
      i = 0;
      while (result_valid !== 1'b1 && i < 300)
      begin
         @(negedge core_clk);
         i++;
      end
      check("result valid", 1, result_valid);
      check("result", {20'h0, v}, {20'h0, result});
      check("starts", n0 + 1, n_starts);
      gap = tr_cyc - fs_cyc;
      check("track gap", 1, gap >= gap_exp - 1 && gap <= gap_exp + 1);
   endtask : t_conv
   // samples before each fall: bit launched one fall earlier
   task link2_frame(input int nclk, output logic [15:0] bits);
      int k;
      bits = 16'h0000;
      link2.chip_select_n = 1'b0;
      #40;
      for (k = 0; k < nclk; k++)
      begin
         bits = {bits[14:0], link2.serial_out_line};
         link2.serial_clock = 1'b0;
         #40;
         link2.serial_clock = 1'b1;
         #40;
      end
   endtask : link2_frame
   task t_abort;
      logic [15:0] bits;
      int          k;
      int          n0;
      n0 = n_starts2;
      link2_frame(6, bits);
      check("abort bits", {19'h0, sample2[11:9]}, {16'h0, bits});
      check("enable", 0, link2.sdo_oe_n);
      check("starts", n0 + 1, n_starts2);
      link2.chip_select_n = 1'b1;
      #1;
      check("abort release", 1, link2.sdo_oe_n);
      for (k = 0; k < 20; k++)
      begin
         #40 link2.serial_clock = 1'b0;
         #40 link2.serial_clock = 1'b1;
      end
      check("idle line", 1, link2.serial_out_line);
      check("idle starts", n0 + 1, n_starts2);
      #400;
   endtask : t_abort
   task t_full2;
      logic [15:0] bits;
      link2_frame(16, bits);
      check("frame bits", {16'h0, 3'b000, sample2, 1'b0}, {16'h0, bits});
      check("release", 1, link2.sdo_oe_n);
      link2.chip_select_n = 1'b1;
      #400;
   endtask : t_full2
   initial
   begin
      #1000000;
      n_errors++;
      complete_run();
   end
   initial
   begin
      rst = 1'b1;
      start = 1'b0;
      sample_in = 12'h000;
      link2.chip_select_n = 1'b1;
      link2.serial_clock = 1'b1;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      foreach (codes[i])
         t_conv(codes[i]);
      t_abort();
      t_full2();
      complete_run();
   end
endmodule : serial_adc_conversion_frame_test
`default_nettype wire
